//--- shared/duc_regs.svh
// Purpose: Register offsets, field positions, reset values and timing
//          counts for the converter update control block.
// Assumes: Byte-wide registers on a plain strobe port, 50 MHz core clock.
// Notes:   Definitions only; include by bare name.
`ifndef DUC_REGS_SVH
`define DUC_REGS_SVH

// ==========================================================
// Register offsets
`define DUC_OFS_CONTROL 2'h0
`define DUC_OFS_VALUE_HIGH 2'h1
`define DUC_OFS_VALUE_LOW 2'h2
`define DUC_OFS_STATUS 2'h3

// ==========================================================
// Control fields
`define DUC_CTL_ENABLE_BIT 0
`define DUC_CTL_PIN_OE_BIT 1
`define DUC_CTL_LEFT_ADJ_BIT 2
`define DUC_CTL_TRIG_SEL_LSB 4
`define DUC_CTL_TRIG_SEL_MSB 6
`define DUC_CTL_AUTO_TRIG_BIT 7
// Bit 3 is reserved and always reads as zero
`define DUC_CTL_WRITE_MASK 8'hf7

// ==========================================================
// Status fields
`define DUC_STS_PENDING_BIT 0
`define DUC_STS_BUSY_BIT 1

// ==========================================================
// Reset values
`define DUC_RST_CONTROL 8'h00
`define DUC_RST_VALUE_HIGH 8'h00
`define DUC_RST_VALUE_LOW 8'h00
`define DUC_RST_SHADOW 10'h000

// ==========================================================
// Timing
`define DUC_CLK_PERIOD_NS 20
`define DUC_CONV_TIME_NS 1000
// Least time, so round up to whole cycles
`define DUC_CONV_CYCLES \
    ((`DUC_CONV_TIME_NS + `DUC_CLK_PERIOD_NS - 1) / `DUC_CLK_PERIOD_NS)

`endif

//--- shared/duc_pkg.sv
// Purpose: Types shared by the converter update control modules.
// Assumes: Constants live in duc_regs.svh.
// Notes:   State of each module is one packed struct.
package duc_pkg;

    // ==========================================================
    // Trigger sources in select-code order
    typedef enum logic [2:0] {
        DUC_TRIG_CMP0,
        DUC_TRIG_CMP1,
        DUC_TRIG_EXT_IRQ0,
        DUC_TRIG_T0_CMP,
        DUC_TRIG_T0_OVF,
        DUC_TRIG_T1_CMP_B,
        DUC_TRIG_T1_OVF,
        DUC_TRIG_T1_CAPT
    } duc_trig_src_e;

    // ==========================================================
    // Edge detector state
    typedef struct packed {
        logic [7:0] prev_flags;
    } duc_edge_s;

    // ==========================================================
    // Main block state
    typedef struct packed {
        logic [7:0] ctrl_reg;
        logic [7:0] value_high_reg;
        logic [7:0] value_low_reg;
        logic la_used_reg;
        logic pending_reg;
        logic [9:0] shadow_reg;
        logic [7:0] busy_cnt_reg;
        logic start_reg;
        logic [7:0] rd_data_reg;
    } duc_state_s;

endpackage

//--- rtl/duc_trig_edge.sv
// Purpose: Pick one trigger flag by select code and flag its rising edge.
// Assumes: Flags are synchronous to i_core_clk.
// Notes:   All eight flags are tracked so that a change of select code
//          never fakes an edge from a flag that was already high.
`timescale 1ns/1ns
module duc_trig_edge
    import duc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_trig_flags,
    input wire logic [2:0] i_trig_select,
    output logic o_sel_flag,
    output logic o_rise
);

    duc_edge_s st_reg;
    duc_edge_s st_next;
    duc_trig_src_e src;
    logic prev_sel;

    assign src = duc_trig_src_e'(i_trig_select);

    // ==========================================================
    // Source selection
    always_comb begin
        case (src)
            DUC_TRIG_CMP0: begin
                o_sel_flag = i_trig_flags[0];
                prev_sel = st_reg.prev_flags[0];
            end
            DUC_TRIG_CMP1: begin
                o_sel_flag = i_trig_flags[1];
                prev_sel = st_reg.prev_flags[1];
            end
            DUC_TRIG_EXT_IRQ0: begin
                o_sel_flag = i_trig_flags[2];
                prev_sel = st_reg.prev_flags[2];
            end
            DUC_TRIG_T0_CMP: begin
                o_sel_flag = i_trig_flags[3];
                prev_sel = st_reg.prev_flags[3];
            end
            DUC_TRIG_T0_OVF: begin
                o_sel_flag = i_trig_flags[4];
                prev_sel = st_reg.prev_flags[4];
            end
            DUC_TRIG_T1_CMP_B: begin
                o_sel_flag = i_trig_flags[5];
                prev_sel = st_reg.prev_flags[5];
            end
            DUC_TRIG_T1_OVF: begin
                o_sel_flag = i_trig_flags[6];
                prev_sel = st_reg.prev_flags[6];
            end
            DUC_TRIG_T1_CAPT: begin
                o_sel_flag = i_trig_flags[7];
                prev_sel = st_reg.prev_flags[7];
            end
            default: begin
                o_sel_flag = 1'b0;
                prev_sel = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Edge detection on the raw flag, independent of interrupt enables
    always_comb begin
        st_next = st_reg;
        st_next.prev_flags = i_trig_flags;
        o_rise = o_sel_flag & ~prev_sel;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

//--- rtl/duc_top.sv
// Purpose: Update control for a 10-bit converter: control register, two
//          input bytes, hidden shadow register and trigger selection.
// Assumes: Single clock, synchronous active-low reset, trigger flags
//          synchronous to the core clock.
// Notes:   Analog reference, drive and accuracy live outside this block.
`timescale 1ns/1ns
`include "duc_regs.svh"
module duc_top
    import duc_pkg::*;
#(
    parameter logic [7:0] CONV_CYCLES = 8'(`DUC_CONV_CYCLES)
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    input wire logic [7:0] i_trig_flags,
    output logic [9:0] o_dac_value,
    output logic o_conv_enable,
    output logic o_pin_drive,
    output logic o_conv_start,
    output logic o_busy
);

    duc_state_s st_reg;
    duc_state_s st_next;
    logic trig_rise;
    logic sel_flag;
    logic wr_ctrl;
    logic wr_high;
    logic wr_low;
    logic auto_mode;
    logic busy;
    logic trig_load;
    logic write_load;

    // ==========================================================
    // Value placement
    // Both adjust forms share this, for write loads and trigger loads
    function automatic logic [9:0] compose(input logic [7:0] high,
                                           input logic [7:0] low,
                                           input logic left_adj);
        logic [9:0] v;
        if (left_adj) begin
            v = {high, low[7:6]};
        end else begin
            v = {high[1:0], low};
        end
        return v;
    endfunction

    // ==========================================================
    // Trigger edge detection
    duc_trig_edge u_trig_edge (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_trig_flags(i_trig_flags),
        .i_trig_select(
            st_reg.ctrl_reg[`DUC_CTL_TRIG_SEL_MSB:`DUC_CTL_TRIG_SEL_LSB]),
        .o_sel_flag(sel_flag),
        .o_rise(trig_rise)
    );

    // ==========================================================
    // Decode
    assign wr_ctrl = i_wr_en && (i_addr == `DUC_OFS_CONTROL);
    assign wr_high = i_wr_en && (i_addr == `DUC_OFS_VALUE_HIGH);
    assign wr_low = i_wr_en && (i_addr == `DUC_OFS_VALUE_LOW);
    assign auto_mode = st_reg.ctrl_reg[`DUC_CTL_AUTO_TRIG_BIT];
    assign busy = (st_reg.busy_cnt_reg != 8'h00);

    // Edges in a busy window are dropped, not remembered
    assign trig_load = auto_mode && trig_rise && !busy
        && !st_reg.pending_reg;
    assign write_load = !auto_mode && wr_high;

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.start_reg = 1'b0;
        st_next.rd_data_reg = 8'h00;

        if (wr_ctrl) begin
            st_next.ctrl_reg = i_wr_data & `DUC_CTL_WRITE_MASK;
        end
        if (wr_low) begin
            st_next.value_low_reg = i_wr_data;
            st_next.pending_reg = 1'b1;
        end
        if (wr_high) begin
            st_next.value_high_reg = i_wr_data;
            st_next.pending_reg = 1'b0;
            // Adjust mode is frozen here, so later flips wait for this
            st_next.la_used_reg =
                st_reg.ctrl_reg[`DUC_CTL_LEFT_ADJ_BIT];
        end

        // Shadow takes all ten bits in one edge, enable not consulted
        if (write_load) begin
            st_next.shadow_reg = compose(i_wr_data, st_reg.value_low_reg,
                st_reg.ctrl_reg[`DUC_CTL_LEFT_ADJ_BIT]);
            st_next.start_reg = 1'b1;
        end else if (trig_load) begin
            st_next.shadow_reg = compose(st_reg.value_high_reg,
                st_reg.value_low_reg, st_reg.la_used_reg);
            st_next.start_reg = 1'b1;
        end

        // Conversion window; only a trigger edge is held off by it
        if (write_load || trig_load) begin
            st_next.busy_cnt_reg = CONV_CYCLES;
        end else if (busy) begin
            st_next.busy_cnt_reg = st_reg.busy_cnt_reg - 8'h01;
        end

        if (i_rd_en) begin
            case (i_addr)
                `DUC_OFS_CONTROL: st_next.rd_data_reg = st_reg.ctrl_reg;
                `DUC_OFS_VALUE_HIGH: begin
                    st_next.rd_data_reg = st_reg.value_high_reg;
                end
                `DUC_OFS_VALUE_LOW: begin
                    st_next.rd_data_reg = st_reg.value_low_reg;
                end
                `DUC_OFS_STATUS: begin
                    st_next.rd_data_reg[`DUC_STS_PENDING_BIT] =
                        st_reg.pending_reg;
                    st_next.rd_data_reg[`DUC_STS_BUSY_BIT] = busy;
                end
                default: st_next.rd_data_reg = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg.ctrl_reg <= `DUC_RST_CONTROL;
            st_reg.value_high_reg <= `DUC_RST_VALUE_HIGH;
            st_reg.value_low_reg <= `DUC_RST_VALUE_LOW;
            st_reg.la_used_reg <= 1'b0;
            st_reg.pending_reg <= 1'b0;
            st_reg.shadow_reg <= `DUC_RST_SHADOW;
            st_reg.busy_cnt_reg <= 8'h00;
            st_reg.start_reg <= 1'b0;
            st_reg.rd_data_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign o_rd_data = st_reg.rd_data_reg;
    assign o_dac_value = st_reg.shadow_reg;
    assign o_conv_enable =
        st_reg.ctrl_reg[`DUC_CTL_ENABLE_BIT];
    // Pin is only driven from a running converter
    assign o_pin_drive = st_reg.ctrl_reg[`DUC_CTL_PIN_OE_BIT]
        && st_reg.ctrl_reg[`DUC_CTL_ENABLE_BIT];
    assign o_conv_start = st_reg.start_reg;
    assign o_busy = busy;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence ctrl_wr_s;
        wr_ctrl;
    endsequence

    sequence low_wr_s;
        wr_low && !trig_load;
    endsequence

    sequence low_then_gap_s;
        low_wr_s ##1 (!wr_high);
    endsequence

    enable_follow_a: assert property (
        ctrl_wr_s |=> o_conv_enable == $past(i_wr_data[0]))
        else $error("converter enable does not follow control write");

    pin_drive_a: assert property (
        ctrl_wr_s |=> o_pin_drive == ($past(i_wr_data[1])
            && $past(i_wr_data[0])))
        else $error("pin drive does not follow control write");

    trig_load_a: assert property (
        (auto_mode && trig_rise && !busy && !st_reg.pending_reg)
        |=> o_conv_start && o_dac_value == compose(
            $past(st_reg.value_high_reg), $past(st_reg.value_low_reg),
            $past(st_reg.la_used_reg)))
        else $error("trigger edge did not load shadow");

    auto_high_hold_a: assert property (
        (auto_mode && wr_high && !trig_rise) |=> $stable(o_dac_value))
        else $error("high write loaded shadow in auto mode");

    write_load_a: assert property (
        (!auto_mode && wr_high) |=> o_dac_value == compose(
            $past(i_wr_data), $past(st_reg.value_low_reg),
            $past(st_reg.ctrl_reg[`DUC_CTL_LEFT_ADJ_BIT])))
        else $error("high write did not load shadow");

    sel_map_a: assert property (
        trig_rise |-> i_trig_flags[st_reg.ctrl_reg[6:4]]
            && !$past(i_trig_flags[st_reg.ctrl_reg[6:4]]))
        else $error("edge taken from the wrong source");

    held_flag_a: assert property (
        (sel_flag && $past(sel_flag)
            && $stable(st_reg.ctrl_reg[6:4])) |-> !trig_rise)
        else $error("held trigger flag restarted conversion");

    busy_drop_a: assert property (
        (auto_mode && busy && !wr_ctrl) |=> !o_conv_start)
        else $error("trigger accepted while busy");

    busy_end_a: assert property (
        $fell(o_busy) |-> $past(st_reg.busy_cnt_reg) == 8'h01)
        else $error("conversion window ended early");

    pending_block_a: assert property (
        low_then_gap_s |-> st_reg.pending_reg && !o_conv_start)
        else $error("update not blocked after low write");

    adj_defer_a: assert property (
        (wr_ctrl && !wr_high && !trig_load) |=> $stable(o_dac_value))
        else $error("adjust change reached shadow without high write");

    shadow_atomic_a: assert property (
        (!write_load && !trig_load) |=> $stable(o_dac_value))
        else $error("shadow changed without a load");

    disabled_load_a: assert property (
        (!o_conv_enable && write_load) |=> o_conv_start)
        else $error("load suppressed while disabled");

    reset_clear_a: assert property (
        @(posedge i_core_clk) disable iff (1'b0)
        !i_rst_n |=> st_reg.ctrl_reg == 8'h00
            && st_reg.value_high_reg == 8'h00
            && st_reg.value_low_reg == 8'h00 && !o_conv_enable)
        else $error("registers not cleared by reset");

endmodule

//--- testbench/duc_src_model.sv
// Purpose: Trigger flag sources plus a converter core that counts starts.
// Assumes: Flags behave as peripheral interrupt flags, cleared by software.
// Notes:   A flag stays high until cleared, so it cannot rise twice alone.
`timescale 1ns/1ns
module duc_src_model
    import duc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_set,
    input wire logic [2:0] i_set_idx,
    input wire logic i_clear,
    input wire logic i_conv_start,
    output logic [7:0] o_flags,
    output logic [7:0] o_starts
);
    // ==========================================================
    // Flags and start counter
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_flags <= 8'h00;
            o_starts <= 8'h00;
        end else begin
            if (i_clear) begin
                o_flags <= 8'h00;
            end else if (i_set) begin
                o_flags[i_set_idx] <= 1'b1;
            end
            if (i_conv_start) begin
                o_starts <= o_starts + 8'h01;
            end
        end
    end
endmodule

//--- testbench/tb_dac_update_control.sv
// Purpose: Self-checking bench for the converter update control block.
// Assumes: Conversion time shortened to 8 cycles by parameter.
// Notes:   Flags come from the source model; software clears them.
`timescale 1ns/1ns
module tb_dac_update_control;
    localparam logic [7:0] CC = 8'h08;
    logic clk, rst_n, wr_en, rd_en, set, clear;
    logic conv_en, pin, start, busy;
    logic [1:0] addr;
    logic [2:0] set_idx;
    logic [7:0] wdata, rd_data, flags, starts;
    logic [9:0] dac;
    int fails, n_checks, cyc;

    duc_top #(.CONV_CYCLES(CC)) u_duc_top (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .i_trig_flags(flags), .o_dac_value(dac), .o_conv_enable(conv_en),
        .o_pin_drive(pin), .o_conv_start(start), .o_busy(busy));
    duc_src_model u_duc_src_model (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_set(set), .i_set_idx(set_idx), .i_clear(clear),
        .i_conv_start(start), .o_flags(flags), .o_starts(starts));

    // ==========================================================
    // Clock, timeout and report
    initial clk = 1'b0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Bus and trigger helpers
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_data", rd_data, exp);
    endtask

    // Returns just after the edge where a taken rise shows a start
    task automatic fire(input logic [2:0] idx);
        @(posedge clk);
        set <= 1'b1;
        set_idx <= idx;
        @(posedge clk);
        set <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic clr();
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        #1;
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        chk("dac", dac, 10'h000);
        chk("en_pin", {conv_en, pin, busy}, 3'b000);
        wr(2'h0, 8'hff);
        rd(2'h0, 8'hf7);
        wr(2'h0, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_manual();
        int n;
        wr(2'h0, 8'h01);
        wr(2'h2, 8'ha5);
        chk("dac", dac, 10'h000);
        rd(2'h3, 8'h01);
        wr(2'h1, 8'h02);
        chk("start", start, 1'b1);
        chk("dac", dac, 10'h2a5);
        wait_idle(n);
        chk("busy_len", 16'(n), 16'(CC));
        chk("en_pin", {conv_en, pin}, 2'b10);
        wr(2'h0, 8'h03);
        chk("pin", pin, 1'b1);
        $display("manual test done");
    endtask

    task automatic t_adjust();
        int n;
        wr(2'h0, 8'h05);
        wr(2'h2, 8'hc0);
        wr(2'h1, 8'h81);
        chk("dac", dac, 10'h207);
        rd(2'h3, 8'h02);
        wait_idle(n);
        wr(2'h0, 8'h01);
        chk("dac", dac, 10'h207);
        wr(2'h1, 8'h01);
        chk("dac", dac, 10'h1c0);
        wait_idle(n);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h03);
        chk("dac", dac, 10'h3c0);
        chk("en", conv_en, 1'b0);
        wait_idle(n);
        $display("adjust test done");
    endtask

    task automatic t_select();
        int n;
        logic [2:0] code;
        for (int i = 0; i < 8; i++) begin
            code = 3'(i);
            wr(2'h0, {1'b1, code, 4'h1});
            wr(2'h1, {5'h00, code});
            chk("start", start, 1'b0);
            fire(code + 3'h1);
            chk("start", start, 1'b0);
            fire(code);
            chk("start", start, 1'b1);
            chk("dac", dac, {code[1:0], 8'hc0});
            wait_idle(n);
            clr();
        end
        $display("select test done");
    endtask

    task automatic t_busy();
        int n;
        logic [7:0] s0;
        wr(2'h0, 8'h81);
        s0 = starts;
        fire(3'h0);
        chk("start", start, 1'b1);
        clr();
        fire(3'h0);
        chk("start", start, 1'b0);
        wait_idle(n);
        repeat (12) @(posedge clk);
        #1;
        chk("starts", starts, s0 + 8'h01);
        clr();
        fire(3'h0);
        chk("start", start, 1'b1);
        wait_idle(n);
        $display("busy test done");
    endtask

    task automatic t_pair();
        clr();
        wr(2'h2, 8'h3c);
        fire(3'h0);
        chk("start", start, 1'b0);
        wr(2'h1, 8'h02);
        chk("start", start, 1'b0);
        clr();
        fire(3'h0);
        chk("start", start, 1'b1);
        chk("dac", dac, 10'h23c);
        $display("pair test done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, wr_en, rd_en, set, clear} = 5'b00000;
        addr = 2'h0;
        wdata = 8'h00;
        set_idx = 3'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_manual();
        t_adjust();
        t_select();
        t_busy();
        t_pair();
        final_report();
    end
endmodule
